/* File: psa_pkg.sv */
// Package for the program space access mapper: widths, field positions,
// access kinds, and the structs that carry the core request and the memory requests.
// Assumes a single core clock domain; no registers are memory mapped.
package psa_pkg;

  // ****************************************************************
  // Widths and field positions
  // ****************************************************************
  localparam int DATA_W      = 16;
  localparam int PROG_W      = 24;
  localparam int PAGE_W      = 8;
  localparam int CTRL_W      = 16;
  localparam int WORD_W      = 24;
  localparam int EA_TOP      = 15;
  localparam int PAGE_TOP    = 7;
  localparam int WIN_ENA_BIT = 2;
  localparam int PC_W        = 23;

  // ****************************************************************
  // Reset values and constants
  // ****************************************************************
  localparam logic [PAGE_W-1:0] TABLE_PAGE_RST  = 8'h00;
  localparam logic [PAGE_W-1:0] WINDOW_PAGE_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CORE_CTRL_RST   = 16'h0000;
  localparam logic [PC_W-1:0]   PC_RST          = 23'h000000;
  localparam logic [PC_W-1:0]   PC_STEP         = 23'h000002;
  localparam logic [1:0]        EXTRA_NONE      = 2'h0;
  localparam logic [1:0]        EXTRA_ONE       = 2'h1;
  localparam logic [1:0]        EXTRA_TWO       = 2'h2;

  // ****************************************************************
  // Access kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    acc_none,
    acc_data_read,
    acc_data_write,
    acc_table_read_low,
    acc_table_read_high,
    acc_table_write_low,
    acc_table_write_high
  } access_kind_t;

  // Request from the core datapath
  typedef struct packed {
    logic                valid;
    access_kind_t        kind;
    logic [DATA_W-1:0]   effective_address;
    logic                byte_mode;
    logic                plain_move;
    logic                in_repeat;
    logic                repeat_edge;
  } core_req_t;

  // Request toward program flash
  typedef struct packed {
    logic                read;
    logic                write;
    logic                config_space;
    logic [PROG_W-1:0]   address;
  } prog_req_t;

  // Request toward ordinary data memory
  typedef struct packed {
    logic                read;
    logic                write;
    logic [DATA_W-1:0]   address;
  } data_req_t;

endpackage

/* File: program_space_access_mapper.sv */
// Program space access mapper: address generation and data steering between
// a 16-bit data datapath and a 24-bit program memory.
// Assumes the core holds a request valid one cycle, the flash answers with
// word data one cycle after a read, and configuration-space holes read zero.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Table address is table page above 16-bit effective address.
// - Table page top bit picks user or configuration space.
// - Window address is window page above effective address bits 14..1, bit 0 zero.
// - Window accesses always hit user memory, address bit 23 zero.
// - Redirect only when effective address top bit and window enable set.
// - Window covers 8000h upward; returns low 16 bits of program word.
// - Fetch and window addresses always have bit 0 zero.
// - Table accesses unaligned; address bit 0 is byte select.
// - Program counter steps by two per program word.
// - Low table read, word mode, returns program bits 15..0.
// - Low table read, byte mode, picks upper or lower low byte.
// - High table read, word mode, returns bits 23..16, upper zero.
// - High table read, byte mode, phantom byte reads as zero.
// - Configuration space takes reads only; writes are refused.
// - Window redirection suspended during any table read or write.
// - Window data reads add execution time, except non-edge repeat iterations.
// - Outside repeat: plain moves one extra cycle, others two.
// - Inside repeat: edge iterations two extra, others none.
module program_space_access_mapper #(
  parameter int DATA_W = psa_pkg::DATA_W,
  parameter int PROG_W = psa_pkg::PROG_W
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire psa_pkg::core_req_t         core_req,
  input  wire logic                       table_page_we,
  input  wire logic [psa_pkg::PAGE_W-1:0] table_page_wdata,
  input  wire logic                       window_page_we,
  input  wire logic [psa_pkg::PAGE_W-1:0] window_page_wdata,
  input  wire logic                       core_control_we,
  input  wire logic [psa_pkg::CTRL_W-1:0] core_control_wdata,
  input  wire logic                       pc_advance,
  input  wire logic                       pc_load,
  input  wire logic [psa_pkg::PC_W-1:0]   pc_load_value,
  input  wire logic [PROG_W-1:0]          prog_rdata,
  output logic [psa_pkg::PAGE_W-1:0]      table_page_reg,
  output logic [psa_pkg::PAGE_W-1:0]      window_page_reg,
  output logic [psa_pkg::CTRL_W-1:0]      core_control_reg,
  output logic [PROG_W-1:0]               fetch_address,
  output psa_pkg::prog_req_t              prog_req,
  output psa_pkg::data_req_t              data_req,
  output logic                            table_write_refused,
  output logic [DATA_W-1:0]               read_data,
  output logic                            read_data_valid,
  output logic [1:0]                      extra_cycles
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic is_table(input psa_pkg::access_kind_t k);
    case (k)
      psa_pkg::acc_table_read_low,
      psa_pkg::acc_table_read_high,
      psa_pkg::acc_table_write_low,
      psa_pkg::acc_table_write_high: begin
        is_table = 1'b1;
      end
      default: begin
        is_table = 1'b0;
      end
    endcase
  endfunction

  function automatic logic is_table_write(input psa_pkg::access_kind_t k);
    case (k)
      psa_pkg::acc_table_write_low,
      psa_pkg::acc_table_write_high: begin
        is_table_write = 1'b1;
      end
      default: begin
        is_table_write = 1'b0;
      end
    endcase
  endfunction

  function automatic logic is_table_read(input psa_pkg::access_kind_t k);
    case (k)
      psa_pkg::acc_table_read_low,
      psa_pkg::acc_table_read_high: begin
        is_table_read = 1'b1;
      end
      default: begin
        is_table_read = 1'b0;
      end
    endcase
  endfunction

  // Table address: page register above the full effective address
  function automatic logic [PROG_W-1:0] table_address(input logic [psa_pkg::PAGE_W-1:0] page,
                                                      input logic [DATA_W-1:0]         ea);
    table_address = {page, ea};
  endfunction

  // Window address: user space only, word aligned, effective address bit 15 dropped
  function automatic logic [PROG_W-1:0] window_address(input logic [psa_pkg::PAGE_W-1:0] page,
                                                       input logic [DATA_W-1:0]         ea);
    window_address = {1'b0, page, ea[psa_pkg::EA_TOP-1:1], 1'b0};
  endfunction

  // Steers a returned program word onto the data bus
  function automatic logic [DATA_W-1:0] steer(input psa_pkg::access_kind_t k,
                                              input logic byte_mode,
                                              input logic byte_sel,
                                              input logic [PROG_W-1:0] word);
    logic [7:0] hi;
    hi    = word[PROG_W-1:DATA_W];
    steer = '0;
    case (k)
      psa_pkg::acc_table_read_high: begin
        // Byte select one picks the phantom byte, which reads zero
        if (!byte_mode || !byte_sel) begin
          steer = {8'h00, hi};
        end
      end
      psa_pkg::acc_table_read_low: begin
        if (byte_mode) begin
          steer = byte_sel ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
        end else begin
          steer = word[DATA_W-1:0];
        end
      end
      default: begin
        // Window reads return only the low word
        steer = word[DATA_W-1:0];
      end
    endcase
  endfunction

  // ****************************************************************
  // Page and control registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      table_page_reg <= psa_pkg::TABLE_PAGE_RST;
    end else if (table_page_we) begin
      table_page_reg <= table_page_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      window_page_reg <= psa_pkg::WINDOW_PAGE_RST;
    end else if (window_page_we) begin
      window_page_reg <= window_page_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      core_control_reg <= psa_pkg::CORE_CTRL_RST;
    end else if (core_control_we) begin
      core_control_reg <= core_control_wdata;
    end
  end

  // ****************************************************************
  // Program counter for instruction fetch
  // ****************************************************************
  logic [psa_pkg::PC_W-1:0] pc_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_reg <= psa_pkg::PC_RST;
    end else if (pc_load) begin
      // Load wins over advance; bit 0 is dropped to keep fetches aligned
      pc_reg <= {pc_load_value[psa_pkg::PC_W-1:1], 1'b0};
    end else if (pc_advance) begin
      pc_reg <= pc_reg + psa_pkg::PC_STEP;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_address <= '0;
    end else begin
      fetch_address <= {1'b0, pc_reg[psa_pkg::PC_W-1:1], 1'b0};
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic                window_hit;
  logic                table_op;
  logic                config_sel;
  logic                refuse;
  logic [PROG_W-1:0]   table_addr;
  logic [PROG_W-1:0]   window_addr;
  logic                data_op;

  always_comb begin
    table_op    = core_req.valid && is_table(core_req.kind);
    data_op     = core_req.valid && ((core_req.kind == psa_pkg::acc_data_read) ||
                                     (core_req.kind == psa_pkg::acc_data_write));
    window_hit  = data_op && (core_req.kind == psa_pkg::acc_data_read) &&
                  core_req.effective_address[psa_pkg::EA_TOP] &&
                  core_control_reg[psa_pkg::WIN_ENA_BIT] && !table_op;
    config_sel  = table_page_reg[psa_pkg::PAGE_TOP];
    refuse      = table_op && config_sel && is_table_write(core_req.kind);
  end

  // Both addresses are formed every cycle; the access kind picks one
  always_comb begin
    table_addr  = table_address(table_page_reg, core_req.effective_address);
    window_addr = window_address(window_page_reg, core_req.effective_address);
  end

  // ****************************************************************
  // Requests toward program and data memory
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      prog_req <= '0;
    end else begin
      prog_req.read         <= window_hit ||
                               (core_req.valid && is_table_read(core_req.kind));
      prog_req.write        <= table_op && is_table_write(core_req.kind) && !refuse;
      prog_req.config_space <= table_op && config_sel;
      prog_req.address      <= window_hit ? window_addr : (table_op ? table_addr : '0);
    end
  end

  // Window writes are not redirected: the window is read only
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_req <= '0;
    end else begin
      data_req.read    <= data_op && !window_hit && (core_req.kind == psa_pkg::acc_data_read);
      data_req.write   <= data_op && (core_req.kind == psa_pkg::acc_data_write);
      data_req.address <= core_req.effective_address;
    end
  end

  // ****************************************************************
  // Refused table writes
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      table_write_refused <= 1'b0;
    end else begin
      table_write_refused <= refuse;
    end
  end

  // ****************************************************************
  // Read steering: remember the pending read one cycle
  // ****************************************************************
  logic                   pend_reg;
  psa_pkg::access_kind_t  pend_kind_reg;
  logic                   pend_byte_reg;
  logic                   pend_sel_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= window_hit || (core_req.valid && is_table_read(core_req.kind));
    end
  end

  // Window reads steer like a plain word read
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_kind_reg <= psa_pkg::acc_none;
    end else begin
      pend_kind_reg <= window_hit ? psa_pkg::acc_data_read : core_req.kind;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_byte_reg <= 1'b0;
    end else begin
      pend_byte_reg <= window_hit ? 1'b0 : core_req.byte_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_sel_reg <= 1'b0;
    end else begin
      pend_sel_reg <= core_req.effective_address[0];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      read_data_valid <= 1'b0;
    end else begin
      read_data_valid <= pend_reg;
    end
  end

  // Read data holds its value until the next read completes
  always_ff @(posedge mclk) begin
    if (rst) begin
      read_data <= '0;
    end else if (pend_reg) begin
      read_data <= steer(pend_kind_reg, pend_byte_reg, pend_sel_reg, prog_rdata);
    end
  end

  // ****************************************************************
  // Extra execution cycles for window reads
  // ****************************************************************
  logic [1:0] extra_next;

  always_comb begin
    extra_next = psa_pkg::EXTRA_NONE;
    if (window_hit) begin
      if (core_req.in_repeat) begin
        extra_next = core_req.repeat_edge ? psa_pkg::EXTRA_TWO : psa_pkg::EXTRA_NONE;
      end else begin
        extra_next = core_req.plain_move ? psa_pkg::EXTRA_ONE : psa_pkg::EXTRA_TWO;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      extra_cycles <= psa_pkg::EXTRA_NONE;
    end else begin
      extra_cycles <= extra_next;
    end
  end

endmodule
`default_nettype wire

/* File: psa_mapper_monitor.sv */
// Checker for the program space access mapper, watching top-level ports.
// Assumes one clock, mclk, with rst synchronous and active high.
`timescale 1ns/100ps
`default_nettype none
module psa_mapper_monitor (
  input wire logic               mclk,
  input wire logic               rst,
  input wire psa_pkg::core_req_t core_req,
  input wire logic [7:0]         table_page_reg,
  input wire logic [7:0]         window_page_reg,
  input wire logic [15:0]        core_control_reg,
  input wire logic               pc_load,
  input wire logic [22:0]        pc_load_value,
  input wire logic [23:0]        prog_rdata,
  input wire logic [23:0]        fetch_address,
  input wire psa_pkg::prog_req_t prog_req,
  input wire psa_pkg::data_req_t data_req,
  input wire logic               table_write_refused,
  input wire logic [15:0]        read_data,
  input wire logic               read_data_valid,
  input wire logic [1:0]         extra_cycles
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  wire logic rd  = core_req.valid && core_req.kind == psa_pkg::acc_data_read;
  wire logic win = rd && core_req.effective_address[15] && core_control_reg[2];
  wire logic tbl = core_req.valid && core_req.kind inside {psa_pkg::acc_table_read_low, psa_pkg::acc_table_read_high};
  wire logic twr = core_req.valid && core_req.kind inside {psa_pkg::acc_table_write_low, psa_pkg::acc_table_write_high};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  tbl_addr_a: assert property (tbl |=> prog_req.read && prog_req.address == {$past(table_page_reg), $past(core_req.effective_address)}) else $error("table address wrong");
  tbl_space_a: assert property (tbl |=> prog_req.config_space == $past(table_page_reg[7])) else $error("table space wrong");
  win_addr_a: assert property (win |=> prog_req.read && !data_req.read && prog_req.address == {1'b0, $past(window_page_reg), $past(core_req.effective_address[14:1]), 1'b0}) else $error("window address wrong");
  win_data_a: assert property (win |-> ##2 read_data_valid && read_data == $past(prog_rdata[15:0])) else $error("window data wrong");
  no_redirect_a: assert property (rd && !win |=> data_req.read && !prog_req.read && data_req.address == $past(core_req.effective_address)) else $error("data access redirected");
  cfg_refuse_a: assert property (twr && table_page_reg[7] |=> table_write_refused && !prog_req.write) else $error("config write not refused");
  extra_plain_a: assert property (win && !core_req.in_repeat |=> extra_cycles == ($past(core_req.plain_move) ? 2'h1 : 2'h2)) else $error("extra cycles wrong");
  extra_repeat_a: assert property (win && core_req.in_repeat |=> extra_cycles == ($past(core_req.repeat_edge) ? 2'h2 : 2'h0)) else $error("repeat extra cycles wrong");
  high_word_a: assert property (tbl && core_req.kind == psa_pkg::acc_table_read_high && !core_req.byte_mode |-> ##2 read_data == {8'h00, $past(prog_rdata[23:16])}) else $error("high word wrong");
  fetch_load_a: assert property (pc_load |-> ##2 fetch_address == {1'b0, $past(pc_load_value[22:1], 2), 1'b0}) else $error("fetch address wrong");
  cover property (win && core_req.in_repeat);
  cover property (twr && table_page_reg[7]);
  cover property (tbl && core_req.byte_mode);
endmodule
bind program_space_access_mapper psa_mapper_monitor psa_mapper_monitor_i (.mclk(mclk), .rst(rst), .core_req(core_req),
  .table_page_reg(table_page_reg), .window_page_reg(window_page_reg), .core_control_reg(core_control_reg),
  .pc_load(pc_load), .pc_load_value(pc_load_value), .prog_rdata(prog_rdata), .fetch_address(fetch_address),
  .prog_req(prog_req), .data_req(data_req), .table_write_refused(table_write_refused), .read_data(read_data),
  .read_data_valid(read_data_valid), .extra_cycles(extra_cycles));
`default_nettype wire

/* File: flash_model.sv */
// Program flash model: a word is a fixed scramble of its address.
// Assumes combinational answer while the mapper's read request stands.
`timescale 1ns/100ps
`default_nettype none
module flash_model (
  input  wire logic               mclk,
  input  wire psa_pkg::prog_req_t prog_req,
  output logic [23:0]             prog_rdata
);
  logic [23:0] last_reg = 24'h000000;
  always_ff @(posedge mclk) begin
    if (prog_req.read) begin
      last_reg <= prog_rdata;
    end
  end
  // Idle shows the inverse of the last word, never a stale copy
  assign prog_rdata = prog_req.read ? {prog_req.address[7:0] ^ 8'hc3, prog_req.address[15:0] ^ 16'h5aa5} : ~last_reg;
endmodule
`default_nettype wire

/* File: tb_program_space_access_mapper.sv */
// Testbench for the program space access mapper.
// Assumes the flash model answers reads in the cycle after the request.
`timescale 1ns/100ps
`default_nettype none
module tb_program_space_access_mapper;
  logic               mclk, rst, tp_we, wp_we, cc_we, pc_advance, pc_load, twr_ref, rvalid;
  logic [7:0]         tp_d, wp_d, tpr, wpr, tpage, wpage;
  logic [15:0]        cc_d, ccr, rdata, c_rd;
  logic [22:0]        pc_val;
  logic [23:0]        prog_rdata, fetch, w, exp;
  logic [1:0]         xc, c_x;
  logic               c_rf, c_rv;
  psa_pkg::core_req_t core_req;
  psa_pkg::prog_req_t pr, c_pr;
  psa_pkg::data_req_t dr, c_dr;
  int                 bad_count = 0, check_count = 0, cycles = 0;
  program_space_access_mapper program_space_access_mapper_i (.mclk(mclk), .rst(rst), .core_req(core_req),
    .table_page_we(tp_we), .table_page_wdata(tp_d), .window_page_we(wp_we), .window_page_wdata(wp_d),
    .core_control_we(cc_we), .core_control_wdata(cc_d), .pc_advance(pc_advance), .pc_load(pc_load),
    .pc_load_value(pc_val), .prog_rdata(prog_rdata), .table_page_reg(tpr), .window_page_reg(wpr),
    .core_control_reg(ccr), .fetch_address(fetch), .prog_req(pr), .data_req(dr),
    .table_write_refused(twr_ref), .read_data(rdata), .read_data_valid(rvalid), .extra_cycles(xc));
  flash_model flash_model_i (.mclk(mclk), .prog_req(pr), .prog_rdata(prog_rdata));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check_val(string name, logic [23:0] e, logic [23:0] got);
    check_count++;
    if (got !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic set_regs(logic [7:0] tp, logic [7:0] wp, logic [15:0] cc);
    @(posedge mclk);
    {tp_we, wp_we, cc_we} <= 3'h7;
    {tp_d, wp_d, cc_d} <= {tp, wp, cc};
    {tpage, wpage} = {tp, wp};
    @(posedge mclk);
    {tp_we, wp_we, cc_we} <= 3'h0;
    #1;
    check_val("page copies", {tp, wp, 8'h00}, {tpr, wpr, 8'h00});
    check_val("control copy", 24'(cc), 24'(ccr));
  endtask
  task automatic access(psa_pkg::access_kind_t k, logic [15:0] ea, logic [3:0] f);
    @(posedge mclk);
    core_req <= '{1'b1, k, ea, f[3], f[2], f[1], f[0]};
    @(posedge mclk);
    core_req.valid <= 1'b0;
    #1;
    {c_pr, c_dr, c_x, c_rf} = {pr, dr, xc, twr_ref};
    @(posedge mclk);
    #1;
    {c_rv, c_rd} = {rvalid, rdata};
  endtask
  task automatic tbl_case(psa_pkg::access_kind_t k, logic [15:0] ea, logic bm, int sel);
    w = {ea[7:0] ^ 8'hc3, ea ^ 16'h5aa5};
    access(k, ea, {bm, 3'h0});
    exp = sel == 0 ? w[15:0] : sel == 1 ? w[15:8] : sel == 2 ? w[7:0] : sel == 3 ? w[23:16] : 24'h0;
    check_val("table address", {tpage, ea}, c_pr.address);
    check_val("table space", 24'(tpage[7]), 24'(c_pr.config_space));
    check_val("table data", {8'h80, exp[15:0]}, {c_rv, 7'h00, c_rd});
  endtask
  task automatic win_case(logic [15:0] ea, logic [3:0] f, logic [1:0] ex);
    access(psa_pkg::acc_data_read, ea, f);
    check_val("window address", {1'b0, wpage, ea[14:1], 1'b0}, c_pr.address);
    check_val("window route", 24'h000004, {c_pr.read, c_dr.read, c_pr.config_space});
    check_val("window data", {8'h01, {wpage[0], ea[14:1], 1'b0} ^ 16'h5aa5}, {7'h00, c_rv, c_rd});
    check_val("extra cycles", 24'(ex), 24'(c_x));
  endtask
  task automatic test_tables;
    set_regs(8'h12, 8'h02, 16'h0004);
    tbl_case(psa_pkg::acc_table_read_low, 16'h3456, 1'b0, 0);
    tbl_case(psa_pkg::acc_table_read_low, 16'h3457, 1'b1, 1);
    tbl_case(psa_pkg::acc_table_read_low, 16'h3456, 1'b1, 2);
    tbl_case(psa_pkg::acc_table_read_high, 16'h3456, 1'b0, 3);
    tbl_case(psa_pkg::acc_table_read_high, 16'h3456, 1'b1, 3);
    tbl_case(psa_pkg::acc_table_read_high, 16'h3457, 1'b1, 4);
    tbl_case(psa_pkg::acc_table_read_low, 16'h8000, 1'b0, 0);
    access(psa_pkg::acc_table_write_high, 16'h0010, 4'h0);
    check_val("user write", 24'h000004, {c_pr.write, c_rf, 1'b0});
    set_regs(8'h81, 8'h02, 16'h0004);
    tbl_case(psa_pkg::acc_table_read_low, 16'h0006, 1'b0, 0);
    access(psa_pkg::acc_table_write_low, 16'h0008, 4'h0);
    check_val("config write", 24'h000002, {c_pr.write, c_rf, 1'b0});
  endtask
  task automatic test_window;
    set_regs(8'h12, 8'h02, 16'h0004);
    win_case(16'h8004, 4'h4, 2'h1);
    win_case(16'h8006, 4'h0, 2'h2);
    win_case(16'h8009, 4'h3, 2'h2);
    win_case(16'h800a, 4'h2, 2'h0);
    set_regs(8'h12, 8'hff, 16'h0004);
    win_case(16'hfffe, 4'h4, 2'h1);
    access(psa_pkg::acc_data_write, 16'h8002, 4'h0);
    check_val("window write", {8'h01, 16'h8002}, {c_pr.read, c_pr.write, 5'h00, c_dr.write, c_dr.address});
    access(psa_pkg::acc_data_read, 16'h7ffe, 4'h4);
    check_val("low data", {8'h01, 16'h7ffe}, {c_pr.read, 6'h00, c_dr.read, c_dr.address});
    set_regs(8'h12, 8'hff, 16'h0000);
    access(psa_pkg::acc_data_read, 16'h8000, 4'h4);
    check_val("disabled", {8'h01, 16'h8000}, {c_pr.read, 6'h00, c_dr.read, c_dr.address});
  endtask
  task automatic test_pc;
    @(posedge mclk);
    {pc_load, pc_val} <= {1'b1, 23'h000101};
    @(posedge mclk);
    {pc_load, pc_advance} <= 2'h1;
    @(posedge mclk);
    pc_advance <= 1'b0;
    #1;
    check_val("fetch load", 24'h000100, fetch);
    @(posedge mclk);
    #1;
    check_val("fetch step", 24'h000102, fetch);
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    {rst, tp_we, wp_we, cc_we, pc_advance, pc_load, tp_d, wp_d, cc_d, pc_val} = '0;
    rst = 1'b1;
    core_req = '0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check_val("reset state", 24'h0, {tpr, wpr, 7'h00, rvalid} | fetch | 24'(ccr));
    test_tables();
    test_window();
    test_pc();
    conclude();
  end
endmodule
`default_nettype wire
